/* File: shared/fifo_flow_map.svh */
`ifndef FIFO_FLOW_MAP_SVH
`define FIFO_FLOW_MAP_SVH

// Carrier FIFO word and local buffer shape
`define FIFO_DATA_W      32
`define BUF_DEPTH        32
`define BUF_PTR_W        5

// Carrier FIFO selection: twelve FIFOs, 4-bit index
`define FIFO_COUNT       4'hC
`define FIFO_SEL_W       4

// Pin sample vector layout
`define PIN_W            35
`define PIN_EMPTY_BIT    34
`define PIN_FULL_BIT     33
`define PIN_CFG_BIT      32
// Sync stages reset to empty, full and released: no start on stale pins
`define PIN_RST          35'h7_0000_0000

// Capability strap values
`define CAP_HAS_PROC     1'b0
`define CAP_HAS_JTAG     1'b0
`define CAP_HAS_SBUS     1'b1
`define CAP_WIDTH_16     1'b0

// Cycles a strobe waits after its FIFO clock period for the flag to settle
`define SETTLE_CYC       2'h2

`endif

/* File: shared/fifo_flow_pkg.sv */
package fifo_flow_pkg;
`include "fifo_flow_map.svh"

  typedef enum logic [2:0] {
    ST_IDLE   = 3'b001,
    ST_XFER   = 3'b010,
    ST_SETTLE = 3'b100
  } xfer_e;

  typedef struct packed {
    logic [`PIN_W-1:0]       pin_s1;
    logic [`PIN_W-1:0]       pin_s2;
    logic                    fclk;
    xfer_e                   rd_st;
    xfer_e                   wr_st;
    logic [1:0]              rd_cnt;
    logic [1:0]              wr_cnt;
    logic                    rd_en;
    logic                    rd_ok;
    logic                    push;
    logic [`FIFO_DATA_W-1:0] push_data;
    logic                    wr_en;
    logic [`FIFO_DATA_W-1:0] wr_data;
    logic [`FIFO_SEL_W-1:0]  sel_in;
    logic [`FIFO_SEL_W-1:0]  sel_out;
    logic                    cfg_oe_n;
    logic                    cfg_lvl;
    logic [3:0]              caps;
  } flow_s;

endpackage : fifo_flow_pkg

/* File: hw/data_fifo.sv */
`timescale 1ns/100ps
module data_fifo #(
  parameter int W     = 32,
  parameter int DEPTH = 32,
  parameter int AW    = 5
) (
  input  wire logic         ref_clk,
  input  wire logic         resetn,
  input  wire logic         in_valid,
  output logic              in_ready,
  input  wire logic [W-1:0] in_data,
  output logic              out_valid,
  input  wire logic         out_ready,
  output logic [W-1:0]      out_data
);
  typedef struct packed {
    logic [AW:0] wp;
    logic [AW:0] rp;
  } ptr_s;

  ptr_s        s;
  ptr_s        n;
  logic [W-1:0] mem [DEPTH];
  logic        do_wr;
  logic        do_rd;

  assign in_ready  = (s.wp[AW] == s.rp[AW]) || (s.wp[AW-1:0] != s.rp[AW-1:0]);
  assign out_valid = (s.wp != s.rp);
  assign out_data  = mem[s.rp[AW-1:0]];
  assign do_wr     = in_valid && in_ready;
  assign do_rd     = out_valid && out_ready;

  always_comb begin
    n = s;
    if (do_wr) begin
      n.wp = s.wp + 1'b1;
    end
    if (do_rd) begin
      n.rp = s.rp + 1'b1;
    end
  end

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      s <= '0;
    end else begin
      s <= n;
    end
  end

  // Storage needs no reset; pointers alone define contents
  always_ff @(posedge ref_clk) begin
    if (do_wr) begin
      mem[s.wp[AW-1:0]] <= in_data;
    end
  end

  chk_no_overrun: assert property (@(posedge ref_clk) disable iff (!resetn)
    in_valid |-> in_ready)
    else $error("buffer written while full");
endmodule : data_fifo

/* File: hw/module_fifo_flow.sv */
// Summary of operation
// - Read input FIFO only when not empty
// - Empty flag qualifies captured words downstream
// - Never write output FIFO while full
// - Processor capability pin held deasserted
// - Boundary-scan capability pin held deasserted
// - Serial bus capability pin asserted
// - Width pin low: 32-bit FIFOs
// - Any of twelve carrier FIFOs selectable
// - Carrier hardware reset before use
// - Hardware reset keeps loaded configuration
// - Hardware reset driven only by carrier
// - Serial bus reset starts each download
// - Serial reset clears configuration only
// - Config line driven low or released
// - Active config line may pause transfers
// - Free-running clock on both FIFO clocks
// - Interface logic on rising edge, one clock
`timescale 1ns/100ps
module module_fifo_flow (
  input  wire logic        ref_clk,
  input  wire logic        resetn,
  input  wire logic        input_empty_flag,
  input  wire logic [31:0] in_fifo_data,
  output logic             in_fifo_rd_en,
  output logic [3:0]       in_fifo_sel,
  output logic             in_fifo_clk,
  input  wire logic        output_full_flag,
  output logic             out_fifo_wr_en,
  output logic [31:0]      out_fifo_data,
  output logic [3:0]       out_fifo_sel,
  output logic             out_fifo_clk,
  input  wire logic [3:0]  fifo_select,
  output logic             has_processor,
  output logic             has_jtag,
  output logic             has_serial_bus,
  output logic             width_16_sel,
  input  wire logic        cfg_line_in,
  output logic             cfg_line_out,
  output logic             cfg_line_oe_n,
  input  wire logic        cfg_drive_req,
  input  wire logic        cfg_pause_en,
  input  wire logic        sbus_reset_cmd,
  input  wire logic        cfg_load_done,
  output logic             config_valid
);
`include "fifo_flow_map.svh"

  fifo_flow_pkg::flow_s s;
  fifo_flow_pkg::flow_s n;

  logic                    configured_ff;
  logic                    nxt_configured;
  logic                    fifo_ce;
  logic                    empty_s;
  logic                    full_s;
  logic                    cfg_active;
  logic                    go;
  logic [`FIFO_DATA_W-1:0] data_s;
  logic                    buf_in_ready;
  logic                    buf_out_valid;
  logic [`FIFO_DATA_W-1:0] buf_out_data;
  logic                    pop;

  function automatic logic sel_ok(input logic [`FIFO_SEL_W-1:0] sel);
    sel_ok = (sel < `FIFO_COUNT);
  endfunction : sel_ok

  // Only the second sync stage is ever read
  assign empty_s    = s.pin_s2[`PIN_EMPTY_BIT];
  assign full_s     = s.pin_s2[`PIN_FULL_BIT];
  assign cfg_active = !s.pin_s2[`PIN_CFG_BIT];
  assign data_s     = s.pin_s2[`FIFO_DATA_W-1:0];
  // Pin outputs change as the FIFO clock falls, stable for its next rise
  assign fifo_ce    = s.fclk;
  assign go         = configured_ff && !(cfg_pause_en && cfg_active);

  data_fifo #(
    .W     (`FIFO_DATA_W),
    .DEPTH (`BUF_DEPTH),
    .AW    (`BUF_PTR_W)
  ) u_buf (
    .ref_clk   (ref_clk),
    .resetn    (resetn),
    .in_valid  (s.push),
    .in_ready  (buf_in_ready),
    .in_data   (s.push_data),
    .out_valid (buf_out_valid),
    .out_ready (pop),
    .out_data  (buf_out_data)
  );

  always_comb begin
    n = s;
    pop = 1'b0;
    n.pin_s1 = {input_empty_flag, output_full_flag, cfg_line_in,
                in_fifo_data};
    n.pin_s2 = s.pin_s1;
    n.fclk = ~s.fclk;
    n.push = 1'b0;
    n.cfg_oe_n = ~cfg_drive_req;
    n.cfg_lvl = 1'b0;
    n.caps = {`CAP_HAS_PROC, `CAP_HAS_JTAG, `CAP_HAS_SBUS,
              `CAP_WIDTH_16};

    // One read in flight; buffer room is checked before the strobe,
    // so a full buffer stalls the reader rather than dropping a word
    case (s.rd_st)
      fifo_flow_pkg::ST_IDLE: begin
        if (fifo_ce && !empty_s && buf_in_ready && go &&
            sel_ok(fifo_select)) begin
          n.rd_en = 1'b1;
          n.rd_ok = !empty_s;
          n.sel_in = fifo_select;
          n.rd_st = fifo_flow_pkg::ST_XFER;
        end
      end
      fifo_flow_pkg::ST_XFER: begin
        if (fifo_ce) begin
          n.rd_en = 1'b0;
          n.rd_cnt = 2'h0;
          n.rd_st = fifo_flow_pkg::ST_SETTLE;
        end
      end
      fifo_flow_pkg::ST_SETTLE: begin
        if (s.rd_cnt == `SETTLE_CYC - 2'h1) begin
          n.push = s.rd_ok;
          n.push_data = data_s;
          n.rd_st = fifo_flow_pkg::ST_IDLE;
        end else begin
          n.rd_cnt = s.rd_cnt + 2'h1;
        end
      end
      default: begin
        n.rd_en = 1'b0;
        n.rd_st = fifo_flow_pkg::ST_IDLE;
      end
    endcase

    // Flag sync lags two cycles, so writes are spaced until it settles
    case (s.wr_st)
      fifo_flow_pkg::ST_IDLE: begin
        if (fifo_ce && buf_out_valid && !full_s && go &&
            sel_ok(fifo_select)) begin
          pop = 1'b1;
          n.wr_en = 1'b1;
          n.wr_data = buf_out_data;
          n.sel_out = fifo_select;
          n.wr_st = fifo_flow_pkg::ST_XFER;
        end
      end
      fifo_flow_pkg::ST_XFER: begin
        if (fifo_ce) begin
          n.wr_en = 1'b0;
          n.wr_cnt = 2'h0;
          n.wr_st = fifo_flow_pkg::ST_SETTLE;
        end
      end
      fifo_flow_pkg::ST_SETTLE: begin
        if (s.wr_cnt == `SETTLE_CYC - 2'h1) begin
          n.wr_st = fifo_flow_pkg::ST_IDLE;
        end else begin
          n.wr_cnt = s.wr_cnt + 2'h1;
        end
      end
      default: begin
        n.wr_en = 1'b0;
        n.wr_st = fifo_flow_pkg::ST_IDLE;
      end
    endcase
  end

  // Hardware reset comes only from the carrier pin, never from here
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      s <= '{pin_s1:    `PIN_RST,
             pin_s2:    `PIN_RST,
             fclk:      1'b0,
             rd_st:     fifo_flow_pkg::ST_IDLE,
             wr_st:     fifo_flow_pkg::ST_IDLE,
             rd_cnt:    2'h0,
             wr_cnt:    2'h0,
             rd_en:     1'b0,
             rd_ok:     1'b0,
             push:      1'b0,
             push_data: '0,
             wr_en:     1'b0,
             wr_data:   '0,
             sel_in:    4'h0,
             sel_out:   4'h0,
             cfg_oe_n:  1'b1,
             cfg_lvl:   1'b0,
             caps:      {`CAP_HAS_PROC, `CAP_HAS_JTAG, `CAP_HAS_SBUS,
                         `CAP_WIDTH_16}};
    end else begin
      s <= n;
    end
  end

  // Configuration survives hardware reset; only the serial bus reset
  // at the start of a download clears it
  always_comb begin
    nxt_configured = configured_ff;
    if (sbus_reset_cmd) begin
      nxt_configured = 1'b0;
    end else if (cfg_load_done) begin
      nxt_configured = 1'b1;
    end
  end

  always_ff @(posedge ref_clk) begin
    configured_ff <= nxt_configured;
  end

  assign in_fifo_rd_en  = s.rd_en;
  assign in_fifo_sel    = s.sel_in;
  assign in_fifo_clk    = s.fclk;
  assign out_fifo_wr_en = s.wr_en;
  assign out_fifo_data  = s.wr_data;
  assign out_fifo_sel   = s.sel_out;
  assign out_fifo_clk   = s.fclk;
  assign has_processor  = s.caps[3];
  assign has_jtag       = s.caps[2];
  assign has_serial_bus = s.caps[1];
  assign width_16_sel   = s.caps[0];
  assign cfg_line_out   = s.cfg_lvl;
  assign cfg_line_oe_n  = s.cfg_oe_n;
  assign config_valid   = configured_ff;

  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!resetn);

  sequence rd_strobe;
    in_fifo_rd_en [*2] ##1 !in_fifo_rd_en;
  endsequence

  sequence wr_strobe;
    out_fifo_wr_en [*2] ##1 !out_fifo_wr_en;
  endsequence

  chk_read_not_empty: assert property (
    $rose(in_fifo_rd_en) |-> !$past(empty_s))
    else $error("read issued while input FIFO empty");

  chk_write_not_full: assert property (
    $rose(out_fifo_wr_en) |-> !$past(full_s))
    else $error("write issued while output FIFO full");

  chk_read_one_period: assert property (
    $rose(in_fifo_rd_en) |-> !in_fifo_clk ##0 rd_strobe)
    else $error("read strobe not one FIFO clock period");

  chk_write_one_period: assert property (
    $rose(out_fifo_wr_en) |-> !out_fifo_clk ##0 wr_strobe
      ##0 !out_fifo_wr_en [*3])
    else $error("write strobe shape or spacing wrong");

  chk_capture_push: assert property (
    $rose(in_fifo_rd_en) |-> ##4 s.push)
    else $error("read word not captured four cycles on");

  chk_caps_static: assert property (
    !has_processor && !has_jtag && has_serial_bus && !width_16_sel)
    else $error("capability pins wrong");

  chk_fifo_clk_runs: assert property (
    $past(resetn) |->
      in_fifo_clk != $past(in_fifo_clk) && out_fifo_clk == in_fifo_clk)
    else $error("FIFO clock not toggling");

  chk_sbus_clears: assert property (
    sbus_reset_cmd |=> !config_valid ##1 (!$rose(in_fifo_rd_en)
      && !$rose(out_fifo_wr_en)))
    else $error("serial reset did not clear configuration");

  chk_pause_holds: assert property (
    (cfg_pause_en && cfg_active) |=> !$rose(in_fifo_rd_en)
      && !$rose(out_fifo_wr_en))
    else $error("transfer started during config pause");

  chk_cfg_drive: assert property (
    cfg_line_oe_n == !$past(cfg_drive_req) && !cfg_line_out)
    else $error("config line drive not following request");

  chk_sel_range: assert property (
    $rose(in_fifo_rd_en) |-> in_fifo_sel < 4'hC)
    else $error("FIFO index out of range");

  chk_reset_quiet: assert property (
    @(posedge ref_clk) disable iff (1'b0)
    !resetn |-> !in_fifo_rd_en && !out_fifo_wr_en)
    else $error("FIFO enable active during reset");
endmodule : module_fifo_flow

/* File: tb/carrier_fifo_model.sv */
`timescale 1ns/100ps
module carrier_fifo_model #(
  parameter int CAP = 8
) (
  input  wire logic        in_fifo_clk,
  input  wire logic        in_fifo_rd_en,
  output logic             input_empty_flag,
  output logic [31:0]      in_fifo_data,
  input  wire logic        out_fifo_clk,
  input  wire logic        out_fifo_wr_en,
  input  wire logic [31:0] out_fifo_data,
  output logic             output_full_flag,
  input  wire logic        cfg_line_out,
  input  wire logic        cfg_line_oe_n,
  output logic             cfg_line_in
);
  logic [31:0] src_q[$];
  logic [31:0] snk_q[$];
  int          underflow = 0;
  int          overflow = 0;

  initial begin
    input_empty_flag = 1'b1;
    in_fifo_data = 32'h0000_0000;
    output_full_flag = 1'b0;
  end

  // Released line floats up through the carrier pull-up
  assign cfg_line_in = cfg_line_oe_n ? 1'b1 : cfg_line_out;

  // Empty read gives a changed word, so a bad read cannot pass unseen
  always @(posedge in_fifo_clk) begin
    if (in_fifo_rd_en) begin
      if (src_q.size() == 0) begin
        underflow <= underflow + 1;
        in_fifo_data <= ~in_fifo_data;
      end else begin
        in_fifo_data <= src_q.pop_front();
      end
    end
    input_empty_flag <= (src_q.size() == 0);
  end

  // Full shows two words early: the module sees the flag late
  always @(posedge out_fifo_clk) begin
    if (out_fifo_wr_en) begin
      if (snk_q.size() >= CAP) begin
        overflow <= overflow + 1;
      end else begin
        snk_q.push_back(out_fifo_data);
      end
    end
    output_full_flag <= (snk_q.size() >= CAP - 2);
  end
endmodule : carrier_fifo_model

/* File: tb/module_fifo_flow_tb.sv */
`timescale 1ns/100ps
module module_fifo_flow_tb;
  logic        ref_clk = 1'b0;
  logic        resetn = 1'b1;
  logic        input_empty_flag, output_full_flag, cfg_line_in;
  logic [31:0] in_fifo_data, out_fifo_data, w, rx;
  logic        in_fifo_rd_en, in_fifo_clk, out_fifo_wr_en, out_fifo_clk;
  logic [3:0]  in_fifo_sel, out_fifo_sel;
  logic [3:0]  fifo_select = 4'h0;
  logic        has_processor, has_jtag, has_serial_bus, width_16_sel;
  logic        cfg_line_out, cfg_line_oe_n, config_valid;
  logic        cfg_drive_req = 1'b0;
  logic        cfg_pause_en = 1'b0;
  logic        sbus_reset_cmd = 1'b0;
  logic        cfg_load_done = 1'b0;
  logic        stall = 1'b0;
  logic        hold = 1'b0;
  logic        rnd_on = 1'b0;
  logic [31:0] exp_q[$];
  int          bad_count = 0;
  int          total_checks = 0;
  int          cycles = 0;

  module_fifo_flow uut (.ref_clk, .resetn, .input_empty_flag, .in_fifo_data,
    .in_fifo_rd_en, .in_fifo_sel, .in_fifo_clk, .output_full_flag,
    .out_fifo_wr_en, .out_fifo_data, .out_fifo_sel, .out_fifo_clk,
    .fifo_select, .has_processor, .has_jtag, .has_serial_bus, .width_16_sel,
    .cfg_line_in, .cfg_line_out, .cfg_line_oe_n, .cfg_drive_req,
    .cfg_pause_en, .sbus_reset_cmd, .cfg_load_done, .config_valid);

  carrier_fifo_model prt (.in_fifo_clk, .in_fifo_rd_en, .input_empty_flag,
    .in_fifo_data, .out_fifo_clk, .out_fifo_wr_en, .out_fifo_data,
    .output_full_flag, .cfg_line_out, .cfg_line_oe_n, .cfg_line_in);

  always #25 ref_clk = ~ref_clk;

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("Error at %0t: got %08h expected %08h", $time, got, exp);
    end
  endtask : chk

  task automatic report_and_stop();
    $display("Checks %0d, mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : report_and_stop

  task automatic tick(input int n = 1);
    repeat (n) @(posedge ref_clk);
    #5;
  endtask : tick

  task automatic send(input int n);
    for (int i = 0; i < n; i++) begin
      w = $urandom;
      prt.src_q.push_back(w);
      exp_q.push_back(w);
    end
  endtask : send

  task automatic drain();
    for (int k = 0; k < 4000 && exp_q.size() > 0; k++) tick();
    chk(exp_q.size(), 32'h0);
  endtask : drain

  task automatic pulse(input int which);
    if (which == 0) sbus_reset_cmd = 1'b1;
    else cfg_load_done = 1'b1;
    tick();
    sbus_reset_cmd = 1'b0;
    cfg_load_done = 1'b0;
    tick();
  endtask : pulse

  // Far-side reader: every word leaving the module is compared in order
  always @(posedge out_fifo_clk) begin
    if (!stall && prt.snk_q.size() > 0) begin
      rx = prt.snk_q.pop_front();
      chk(rx, exp_q.size() > 0 ? exp_q.pop_front() : ~rx);
    end
  end

  always @(posedge ref_clk) begin
    stall <= hold || (rnd_on && $urandom_range(0, 2) == 0);
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      bad_count++;
      report_and_stop();
    end
  end

  initial begin
    int k;
    int t;
    k = $urandom(32'hFD7D6C87);
    t = 0;
    #5 resetn = 1'b0;
    tick(10);
    chk({in_fifo_rd_en, out_fifo_wr_en, in_fifo_clk}, 32'h0);
    resetn = 1'b1;
    tick(2);
    chk({has_processor, has_jtag, has_serial_bus,
         width_16_sel}, 32'h2);
    for (k = 0; k < 8; k++) begin
      w[0] = in_fifo_clk;
      tick();
      t += (w[0] != in_fifo_clk);
      chk(out_fifo_clk, in_fifo_clk);
    end
    chk(t, 32'h8);
    pulse(0);
    chk(config_valid, 32'h0);
    send(3);
    tick(40);
    chk(prt.src_q.size(), 32'h3);
    pulse(1);
    drain();
    for (k = 0; k < 12; k++) begin
      fifo_select = k[3:0];
      send(2);
      drain();
      chk({in_fifo_sel, out_fifo_sel}, {24'h0, k[3:0], k[3:0]});
    end
    fifo_select = 4'hC;
    send(1);
    tick(40);
    chk(prt.src_q.size(), 32'h1);
    fifo_select = 4'h5;
    drain();
    // Stalled far side: sink fills, then the 32-word buffer refuses
    hold = 1'b1;
    send(50);
    tick(500);
    t = prt.src_q.size();
    tick(60);
    chk(prt.src_q.size(), t);
    chk(t, 50 - 32 - prt.snk_q.size());
    pulse(0);
    chk(config_valid, 32'h0);
    chk(has_serial_bus, 32'h1);
    pulse(1);
    hold = 1'b0;
    rnd_on = 1'b1;
    drain();
    send(30);
    drain();
    rnd_on = 1'b0;
    cfg_drive_req = 1'b1;
    tick(2);
    chk({cfg_line_oe_n, cfg_line_in}, 32'h0);
    cfg_pause_en = 1'b1;
    send(2);
    tick(40);
    chk(prt.src_q.size(), 32'h2);
    cfg_drive_req = 1'b0;
    tick(2);
    chk(cfg_line_in, 32'h1);
    drain();
    cfg_pause_en = 1'b0;
    resetn = 1'b0;
    tick(2);
    chk({in_fifo_rd_en, out_fifo_wr_en, in_fifo_clk}, 32'h0);
    resetn = 1'b1;
    tick(2);
    chk(config_valid, 32'h1);
    send(4);
    drain();
    chk(prt.overflow, 32'h0);
    chk(prt.underflow, 32'h0);
    report_and_stop();
  end
endmodule : module_fifo_flow_tb
